// ---- src/e1_natbit_params.svh ----
// offsets, fields, reset values and timing counts of the national-bit block.
// assumes: included by bare name from design files.
`ifndef E1_NATBIT_PARAMS_SVH
`define E1_NATBIT_PARAMS_SVH

// register indices; byte address is four times the index
`define MASK_INDEX        8'h19
`define CTRL_INDEX        8'h1a
`define STAT_INDEX        8'h20
`define TRIS_INDEX        8'h21

// mask word fields
`define MASK_WRAP_BIT     6
`define MASK_ERR_BIT      5
`define MASK_NIBCHG_BIT   4
`define MASK_BITCHG_BIT   3
`define MASK_EIGHT_BIT    2
`define MASK_B6CHG_BIT    1
`define MASK_B5CHG_BIT    0

// control word fields
`define CTRL_OEN_BIT      7
`define CTRL_SUSP_BIT     6
`define CTRL_ACK_BIT      5
`define CTRL_CCS_BIT      4
`define CTRL_REGSIG_BIT   3
`define CTRL_CLR_BIT      2
`define CTRL_UPPER_BIT    1
`define CTRL_SLOW_BIT     0

// tristate select word fields
`define TRIS_DATA_BIT     1
`define TRIS_CTRL_BIT     0

`define MASK_RESET        8'h00
`define CTRL_RESET        8'h00
`define TRIS_RESET        8'h00
`define IRQ_VECTOR        8'h02

// backplane timing in 4 MHz clock ticks, and the last bit six repeat count
`define TICKS_PER_FRAME   9'h1ff
`define SLOW_PHASE_BIT    5
`define SAME_NIBBLE_LAST  3'h7

`endif

// ---- src/e1_natbit_pkg.sv ----
// types of the national-bit control block.
// assumes: compiled before the design modules.
package e1_natbit_pkg;

    // data phase kind held between address and data phase
    typedef enum logic [1:0] {
        phase_idle  = 2'b00,
        phase_write = 2'b01,
        phase_read  = 2'b10
    } bus_phase_type;

    typedef logic [7:0] reg_byte_type;

endpackage : e1_natbit_pkg

// ---- src/channel_clock_gen.sv ----
// 64 kHz channel clock derived from a 4 MHz backplane clock level.
// assumes: bit_clock_in and frame_start are synchronous to clk.
`timescale 1ns/1ps
`include "e1_natbit_params.svh"

module channel_clock_gen (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic bit_clock_in,
    input  wire logic frame_start,
    input  wire logic enable,
    output logic      slow_clk_q,
    output logic      slow_rise_q
);

    logic       bit_clock_prev_q;
    logic       tick;
    logic [8:0] tick_cnt_q;

    // tick on each 4 MHz rise
    assign tick = bit_clock_in & ~bit_clock_prev_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bit_clock_prev_q <= 1'b0;
        end else begin
            bit_clock_prev_q <= bit_clock_in;
        end
    end

    // position within the frame, 16 ticks per channel
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tick_cnt_q <= 9'h000;
        end else if (tick) begin
            if (frame_start || tick_cnt_q == `TICKS_PER_FRAME) begin
                tick_cnt_q <= 9'h000;
            end else begin
                tick_cnt_q <= tick_cnt_q + 9'h001;
            end
        end
    end

    // high in channels 2-3, 6-7 ...; rises at 2, 6 ... 30
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            slow_clk_q  <= 1'b0;
            slow_rise_q <= 1'b0;
        end else begin
            slow_clk_q  <= enable & tick_cnt_q[`SLOW_PHASE_BIT];
            slow_rise_q <= enable & ~slow_clk_q & tick_cnt_q[`SLOW_PHASE_BIT];
        end
    end

endmodule : channel_clock_gen

// ---- src/e1_natbit_irq_sig_ctrl.sv ----
// national-bit interrupts, request pin, stream tristate and signalling modes
// of an E1 framer, behind an AHB-Lite register slave.
// assumes: inputs synchronous to hclk; request pin is open drain outside.
// Behaviour
// (R1) unmasked test counter wrap raises vector 02
// (R2) unmasked test pattern error raises vector 02
// (R3) unmasked national nibble change raises vector 02
// (R4) unmasked national bit change raises vector 02
// (R5) unmasked eighth equal bit six nibble raises vector 02
// (R6) unmasked bit six nibble change raises vector 02
// (R7) unmasked bit five change raises vector 02; zero mask blocks
// (R8) output enable low floats both streams, else per-stream selects
// (R9) suspend floats request output, ignores all sources
// (R10) acknowledge bit toggle clears pending, releases request
// (R11) mode bit picks common or associated channel signalling
// (R12) tx signalling from registers or control stream
// (R13) counter clear zeroes and holds status counters
// (R14) nibble position bit picks upper or lower half slot
// (R15) slow mode moves control stream on internal 64 kHz clock
// (R16) tx 64 kHz clock rises between channels 1-2, 5-6 ... 29-30
// (R17) rx 64 kHz clock, same channel times, from line timebase
// (R18) slow mode off runs control streams at 2.048 rate
// (R19) selected data stream floats on loss or all-ones alarm
// (R20) request low while pending; vector latched for reading
`timescale 1ns/1ps
`include "e1_natbit_params.svh"

module e1_natbit_irq_sig_ctrl (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    input  wire logic        test_error,
    input  wire logic        natbit_strobe,
    input  wire logic [3:0]  rx_natbits,
    input  wire logic        nibble_strobe,
    input  wire logic [15:0] rx_nibbles,
    input  wire logic        loss_of_signal,
    input  wire logic        loss_frame_sync,
    input  wire logic        loss_crc_sync,
    input  wire logic        rx_all_ones,
    input  wire logic        loss_mf_sync,
    input  wire logic        rx_ais16,
    input  wire logic        data_stream_in,
    input  wire logic        control_stream_in,
    input  wire logic        control_in_stream,
    input  wire logic [7:0]  control_in_slot,
    input  wire logic [3:0]  sig_register_nibble,
    input  wire logic        backplane_4mhz_clock,
    input  wire logic        tx_frame_start,
    input  wire logic        line_4mhz_clock,
    input  wire logic        rx_frame_start,
    output logic             data_out_stream,
    output logic             data_out_oe,
    output logic             control_out_stream,
    output logic             control_out_oe,
    output logic             irq_n_out,
    output logic             irq_oe,
    output logic             tx_common_channel_mode,
    output logic             tx_sig_from_registers,
    output logic             status_counter_clear,
    output logic             sig_nibble_upper_half,
    output logic [3:0]       tx_sig_nibble,
    output logic             tx_slow_clock,
    output logic             rx_slow_channel_clock_out
);

    e1_natbit_pkg::bus_phase_type phase_q;
    e1_natbit_pkg::reg_byte_type  mask_q;
    e1_natbit_pkg::reg_byte_type  ctrl_q;
    e1_natbit_pkg::reg_byte_type  tris_q;
    e1_natbit_pkg::reg_byte_type  vector_q;
    e1_natbit_pkg::reg_byte_type  err_cnt_q;
    logic [7:0]  idx_q;
    logic [7:0]  idx_now;
    logic        pending_q;
    logic        ack_edge;
    logic        wr_ctrl;
    logic [3:0]  natbits_prev_q;
    logic [15:0] nibbles_prev_q;
    logic        bits_valid_q;
    logic        nibs_valid_q;
    logic [2:0]  same_cnt_q;
    logic        ev_wrap;
    logic        ev_err;
    logic        ev_nibchg;
    logic        ev_bitchg;
    logic        ev_eight;
    logic        ev_b6chg;
    logic        ev_b5chg;
    logic        any_event;
    logic        tx_rise;
    logic        rx_rise;
    logic        rx_clk;

    ////////////////////////////////////////////////////////////////////////
    // bus slave: zero wait state, always OKAY
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign idx_now   = haddr[9:2];
    assign wr_ctrl   = (phase_q == e1_natbit_pkg::phase_write) && (idx_q == `CTRL_INDEX);

    // address phase capture
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            phase_q <= e1_natbit_pkg::phase_idle;
            idx_q   <= 8'h00;
        end else if (hready) begin
            idx_q <= idx_now;
            if (hsel && htrans[1]) begin
                phase_q <= hwrite ? e1_natbit_pkg::phase_write : e1_natbit_pkg::phase_read;
            end else begin
                phase_q <= e1_natbit_pkg::phase_idle;
            end
        end
    end

    // read data registered in address phase; unmapped reads zero
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (hready && hsel && htrans[1] && !hwrite) begin
            if (idx_now == `MASK_INDEX) begin
                hrdata <= {24'h00_0000, mask_q};
            end else if (idx_now == `CTRL_INDEX) begin
                hrdata <= {24'h00_0000, ctrl_q};
            end else if (idx_now == `STAT_INDEX) begin
                hrdata <= {15'h0000, pending_q, err_cnt_q, vector_q}; // R20
            end else if (idx_now == `TRIS_INDEX) begin
                hrdata <= {24'h00_0000, tris_q};
            end else begin
                hrdata <= 32'h0000_0000;
            end
        end
    end

    // writable words; bit 7 of the mask word reads as zero
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mask_q <= `MASK_RESET;
            ctrl_q <= `CTRL_RESET;
            tris_q <= `TRIS_RESET;
        end else if (phase_q == e1_natbit_pkg::phase_write) begin
            if (idx_q == `MASK_INDEX) begin
                mask_q <= {1'b0, hwdata[6:0]};
            end else if (idx_q == `CTRL_INDEX) begin
                ctrl_q <= hwdata[7:0];
            end else if (idx_q == `TRIS_INDEX) begin
                tris_q <= {6'h00, hwdata[1:0]};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // test error counter, cleared and held while the clear bit is set
    assign ev_wrap = test_error && err_cnt_q == 8'hff && !ctrl_q[`CTRL_CLR_BIT];
    assign ev_err  = test_error;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            err_cnt_q <= 8'h00;
        end else if (ctrl_q[`CTRL_CLR_BIT]) begin
            err_cnt_q <= 8'h00; // R13
        end else if (test_error) begin
            err_cnt_q <= err_cnt_q + 8'h01; // R1
        end
    end

    // national bit and nibble history; first sample only primes it
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            natbits_prev_q <= 4'h0;
            bits_valid_q   <= 1'b0;
        end else if (natbit_strobe) begin
            natbits_prev_q <= rx_natbits;
            bits_valid_q   <= 1'b1;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            nibbles_prev_q <= 16'h0000;
            nibs_valid_q   <= 1'b0;
        end else if (nibble_strobe) begin
            nibbles_prev_q <= rx_nibbles;
            nibs_valid_q   <= 1'b1;
        end
    end

    // rx_nibbles lanes: bit five lowest, bit eight highest
    assign ev_bitchg = natbit_strobe && bits_valid_q && rx_natbits != natbits_prev_q; // R4
    assign ev_b5chg  = natbit_strobe && bits_valid_q && rx_natbits[0] != natbits_prev_q[0]; // R7
    assign ev_nibchg = nibble_strobe && nibs_valid_q && rx_nibbles != nibbles_prev_q; // R3
    assign ev_b6chg  = nibble_strobe && nibs_valid_q && rx_nibbles[7:4] != nibbles_prev_q[7:4]; // R6
    assign ev_eight  = nibble_strobe && nibs_valid_q && !ev_b6chg && same_cnt_q == 3'h6; // R5

    // bit six repeats, saturating after the eighth
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            same_cnt_q <= 3'h0;
        end else if (nibble_strobe && nibs_valid_q) begin
            if (ev_b6chg) begin
                same_cnt_q <= 3'h0;
            end else if (same_cnt_q != `SAME_NIBBLE_LAST) begin
                same_cnt_q <= same_cnt_q + 3'h1; // R5
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // mask gating; suspend discards every source rather than deferring it
    assign any_event = !ctrl_q[`CTRL_SUSP_BIT] && ( // R9
        (ev_wrap   && mask_q[`MASK_WRAP_BIT])   || // R1
        (ev_err    && mask_q[`MASK_ERR_BIT])    || // R2
        (ev_nibchg && mask_q[`MASK_NIBCHG_BIT]) || // R3
        (ev_bitchg && mask_q[`MASK_BITCHG_BIT]) || // R4
        (ev_eight  && mask_q[`MASK_EIGHT_BIT])  || // R5
        (ev_b6chg  && mask_q[`MASK_B6CHG_BIT])  || // R6
        (ev_b5chg  && mask_q[`MASK_B5CHG_BIT]));   // R7

    // either direction of the acknowledge bit counts
    assign ack_edge = wr_ctrl && (hwdata[`CTRL_ACK_BIT] != ctrl_q[`CTRL_ACK_BIT]); // R10

    // pending flag: a new event in the acknowledge cycle wins
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pending_q <= 1'b0;
            vector_q  <= 8'h00;
        end else if (any_event) begin
            pending_q <= 1'b1; // R20
            vector_q  <= `IRQ_VECTOR;
        end else if (ack_edge) begin
            pending_q <= 1'b0; // R10
            vector_q  <= 8'h00;
        end
    end

    // request pin: low while pending, released when suspended
    assign irq_n_out = ~pending_q; // R20
    assign irq_oe    = ~ctrl_q[`CTRL_SUSP_BIT] & pending_q; // R9

    ////////////////////////////////////////////////////////////////////////
    // signalling mode levels to the transmitter
    assign tx_common_channel_mode = ctrl_q[`CTRL_CCS_BIT]; // R11
    assign tx_sig_from_registers  = ctrl_q[`CTRL_REGSIG_BIT]; // R12
    assign status_counter_clear   = ctrl_q[`CTRL_CLR_BIT]; // R13
    assign sig_nibble_upper_half  = ctrl_q[`CTRL_UPPER_BIT]; // R14

    // transmit signalling nibble source and half-slot selection
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tx_sig_nibble <= 4'h0;
        end else if (ctrl_q[`CTRL_REGSIG_BIT]) begin
            tx_sig_nibble <= sig_register_nibble; // R12
        end else if (ctrl_q[`CTRL_UPPER_BIT]) begin
            tx_sig_nibble <= control_in_slot[7:4]; // R14
        end else begin
            tx_sig_nibble <= control_in_slot[3:0]; // R14
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // 64 kHz channel clocks, transmit from backplane, receive from line
    channel_clock_gen tx_clock_gen (
        .clk          (hclk),
        .rst_n        (hresetn),
        .bit_clock_in (backplane_4mhz_clock),
        .frame_start  (tx_frame_start),
        .enable       (ctrl_q[`CTRL_SLOW_BIT]),
        .slow_clk_q   (tx_slow_clock), // R16
        .slow_rise_q  (tx_rise)
    );

    channel_clock_gen rx_clock_gen (
        .clk          (hclk),
        .rst_n        (hresetn),
        .bit_clock_in (line_4mhz_clock),
        .frame_start  (rx_frame_start),
        .enable       (ctrl_q[`CTRL_SLOW_BIT]),
        .slow_clk_q   (rx_clk),
        .slow_rise_q  (rx_rise)
    );

    assign rx_slow_channel_clock_out = rx_clk; // R17

    // streams: slow mode samples the control input on each 64 kHz rise only
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            control_out_stream <= 1'b0;
            data_out_stream    <= 1'b0;
        end else begin
            data_out_stream <= data_stream_in;
            if (!ctrl_q[`CTRL_SLOW_BIT]) begin
                control_out_stream <= control_stream_in; // R18
            end else if (tx_rise) begin
                control_out_stream <= control_in_stream; // R15
            end
        end
    end

    // tristate: master enable first, then per-stream alarm floats
    assign data_out_oe = ctrl_q[`CTRL_OEN_BIT] && // R8
        !(tris_q[`TRIS_DATA_BIT] && (loss_of_signal || loss_frame_sync || loss_crc_sync || rx_all_ones)); // R19
    assign control_out_oe = ctrl_q[`CTRL_OEN_BIT] && // R8
        !(tris_q[`TRIS_CTRL_BIT] && (loss_mf_sync || rx_ais16));

    ////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    sequence s_ack_write;
        wr_ctrl && hwdata[`CTRL_ACK_BIT] != ctrl_q[`CTRL_ACK_BIT] && !any_event;
    endsequence
    sequence s_released;
        !pending_q && irq_n_out;
    endsequence

    a_ack_release: assert property ( // R10
        s_ack_write |=> s_released)
        else $error("ack toggle kept request");

    a_wrap_raise: assert property ( // R1
        (ev_wrap && mask_q[`MASK_WRAP_BIT] && !ctrl_q[`CTRL_SUSP_BIT]) |=> (pending_q && vector_q == 8'h02))
        else $error("wrap raised no vector");

    a_err_raise: assert property ( // R2
        (test_error && mask_q[`MASK_ERR_BIT] && !ctrl_q[`CTRL_SUSP_BIT]) |=> !irq_n_out)
        else $error("test error raised no request");

    a_mask_blocks: assert property ( // R7
        (!pending_q && mask_q == 8'h00) |=> !pending_q)
        else $error("masked source raised request");

    a_suspend_float: assert property ( // R9
        (ctrl_q[`CTRL_SUSP_BIT] && !pending_q) |=> (!irq_oe && !pending_q))
        else $error("suspended request drove");

    a_counter_hold: assert property ( // R13
        ctrl_q[`CTRL_CLR_BIT] ##1 ctrl_q[`CTRL_CLR_BIT] |-> err_cnt_q == 8'h00)
        else $error("counter not held at zero");

    a_oen_float: assert property ( // R8
        !ctrl_q[`CTRL_OEN_BIT] |-> (!data_out_oe && !control_out_oe))
        else $error("stream driven while disabled");

    a_alarm_float: assert property ( // R19
        (tris_q[`TRIS_DATA_BIT] && loss_of_signal) |-> !data_out_oe)
        else $error("data stream driven in alarm");

    a_slow_hold: assert property ( // R15
        (ctrl_q[`CTRL_SLOW_BIT] && !tx_rise) ##1 ctrl_q[`CTRL_SLOW_BIT] |-> $stable(control_out_stream))
        else $error("control stream moved off rise");

    a_eight_same: assert property ( // R5
        (ev_eight && mask_q[`MASK_EIGHT_BIT] && !ctrl_q[`CTRL_SUSP_BIT]) |=> pending_q)
        else $error("eighth nibble missed");

endmodule : e1_natbit_irq_sig_ctrl

// ---- test/backplane_model.sv ----
// backplane and line timing: 4 mhz levels, frame starts, slow data.
// assumes: clk is the block clock.
`timescale 1ns/1ps

module backplane_model (
    input  wire logic clk,
    input  wire logic rst_n,
    output logic      bp_clk,
    output logic      line_clk,
    output logic      tx_fs,
    output logic      rx_fs,
    output logic      cin
);
    logic [5:0] bp_q;
    logic [5:0] ln_q;
    logic [8:0] bp_tick_q;
    logic [8:0] ln_tick_q;

    // 50 and 51 cycle periods keep the clocks unrelated
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            {bp_q, ln_q, bp_tick_q, ln_tick_q} <= 30'h0;
        end else begin
            bp_q <= (bp_q == 6'h31) ? 6'h00 : bp_q + 6'h01;
            ln_q <= (ln_q == 6'h32) ? 6'h00 : ln_q + 6'h01;
            if (bp_q == 6'h31) bp_tick_q <= bp_tick_q + 9'h001;
            if (ln_q == 6'h32) ln_tick_q <= ln_tick_q + 9'h001;
        end
    end

    // 512 ticks a frame; start marks channel 0
    assign bp_clk   = (bp_q < 6'h19);
    assign line_clk = (ln_q < 6'h19);
    assign tx_fs    = (bp_tick_q == 9'h000);
    assign rx_fs    = (ln_tick_q == 9'h000);
    assign cin      = bp_tick_q[6];
endmodule : backplane_model

// ---- test/tb.sv ----
// self-checking bench for the national-bit control block.
// assumes: ahb-lite slave; byte address is 4 times the index.
`timescale 1ns/1ps

module tb;
    logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic        test_error, natbit_strobe, nibble_strobe, loss_of_signal, loss_frame_sync;
    logic        loss_crc_sync, rx_all_ones, loss_mf_sync, rx_ais16, data_stream_in, control_stream_in;
    logic        control_in_stream, backplane_4mhz_clock, tx_frame_start, line_4mhz_clock, rx_frame_start;
    logic [3:0]  rx_natbits, sig_register_nibble, tx_sig_nibble;
    logic [15:0] rx_nibbles;
    logic [7:0]  control_in_slot, ctl;
    logic        data_out_stream, data_out_oe, control_out_stream, control_out_oe, irq_n_out, irq_oe;
    logic        tx_common_channel_mode, tx_sig_from_registers, status_counter_clear;
    logic        sig_nibble_upper_half, tx_slow_clock, rx_slow_channel_clock_out;
    int          err_total, n_tests, cyc, t, r;

    assign hready = hreadyout;
    e1_natbit_irq_sig_ctrl e1_natbit_irq_sig_ctrl_i (.*);
    backplane_model backplane_model_i (.clk(hclk), .rst_n(hresetn), .bp_clk(backplane_4mhz_clock),
        .line_clk(line_4mhz_clock), .tx_fs(tx_frame_start), .rx_fs(rx_frame_start), .cin(control_in_stream));

    ////////////////////////////////////////////////////////////////////////
    // clock and hang guard
    initial begin
        hclk = 1'b0;
        forever #2.5 hclk = ~hclk;
    end
    always @(posedge hclk) begin
        cyc++;
        if (cyc == 80000) begin
            err_total++;
            finish_test();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        n_tests++;
        if (s !== e) begin
            $display("unexpected %s expected %h seen %h", nm, e, s);
            err_total++;
        end
    endtask : chk

    task automatic rdy;
        @(posedge hclk);
        for (int k = 0; k < 100 && hready !== 1'b1; k++) @(posedge hclk);
    endtask : rdy

    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] wd);
        @(posedge hclk);
        hsel   <= 1'b1;
        htrans <= 2'b10;
        haddr  <= a;
        hwrite <= w;
        rdy();
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        rdy();
        rd = hrdata;
    endtask : bus

    task automatic msk(input logic [7:0] d);
        bus(1'b1, 32'h64, {24'h0, d});
    endtask : msk

    task automatic wctl(input logic [7:0] d);
        ctl = d;
        bus(1'b1, 32'h68, {24'h0, d});
    endtask : wctl

    task automatic ack;
        wctl(ctl ^ 8'h20);
    endtask : ack

    task automatic err_pulse;
        @(posedge hclk);
        test_error <= 1'b1;
        @(posedge hclk);
        test_error <= 1'b0;
    endtask : err_pulse

    task automatic rx(input logic [3:0] b, input logic [15:0] n);
        @(posedge hclk);
        natbit_strobe <= 1'b1;
        nibble_strobe <= 1'b1;
        rx_natbits    <= b;
        rx_nibbles    <= n;
        @(posedge hclk);
        natbit_strobe <= 1'b0;
        nibble_strobe <= 1'b0;
    endtask : rx

    task automatic irq_is(input logic p);
        repeat (2) @(posedge hclk);
        @(negedge hclk);
        chk("irq_n_out", {31'h0, ~p}, {31'h0, irq_n_out});
        chk("irq_oe", {31'h0, p}, {31'h0, irq_oe});
    endtask : irq_is

    task automatic rises(input int n);
        logic pt, pr;
        t = 0;
        r = 0;
        pt = tx_slow_clock;
        pr = rx_slow_channel_clock_out;
        repeat (n) begin
            @(negedge hclk);
            if (tx_slow_clock === 1'b1 && pt === 1'b0) t++;
            if (rx_slow_channel_clock_out === 1'b1 && pr === 1'b0) r++;
            pt = tx_slow_clock;
            pr = rx_slow_channel_clock_out;
        end
    endtask : rises

    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        bus(1'b0, 32'h64, 32'h0);
        chk("mask", 32'h0, rd);
        chk("hresp", 32'h0, {31'h0, hresp});
        bus(1'b0, 32'h68, 32'h0);
        chk("ctrl", 32'h0, rd);
        bus(1'b0, 32'h40, 32'h0);
        chk("unmapped", 32'h0, rd);
        irq_is(1'b0);
    endtask : t_reset

    task automatic t_error;
        msk(8'h20);
        wctl(8'h80);
        err_pulse();
        irq_is(1'b1);
        bus(1'b0, 32'h80, 32'h0);
        chk("status", 32'h0001_0102, rd);
        ack();
        irq_is(1'b0);
        err_pulse();
        irq_is(1'b1);
        ack();
        irq_is(1'b0);
        msk(8'h00);
        wctl(8'h84);
        err_pulse();
        bus(1'b0, 32'h80, 32'h0);
        chk("cleared count", 32'h0, {24'h0, rd[15:8]});
        chk("clear out", 32'h1, {31'h0, status_counter_clear});
        wctl(8'h80);
        err_pulse();
        irq_is(1'b0);
        bus(1'b0, 32'h80, 32'h0);
        chk("count", 32'h1, {24'h0, rd[15:8]});
    endtask : t_error

    task automatic t_suspend;
        msk(8'h20);
        wctl(8'hc0);
        err_pulse();
        irq_is(1'b0);
        wctl(8'h80);
        irq_is(1'b0);
    endtask : t_suspend

    task automatic t_natbits;
        msk(8'h08);
        rx(4'h0, 16'h0000);
        rx(4'h8, 16'h0000);
        irq_is(1'b1);
        ack();
        msk(8'h01);
        rx(4'hc, 16'h0000);
        irq_is(1'b0);
        rx(4'hd, 16'h0000);
        irq_is(1'b1);
        ack();
    endtask : t_natbits

    task automatic t_nibbles;
        msk(8'h10);
        rx(4'hd, 16'h1000);
        irq_is(1'b1);
        ack();
        msk(8'h02);
        rx(4'hd, 16'h1001);
        irq_is(1'b0);
        rx(4'hd, 16'h1011);
        irq_is(1'b1);
        ack();
        msk(8'h04);
        for (int i = 0; i < 7; i++) begin
            if (i == 6) irq_is(1'b0);
            rx(4'hd, 16'h1011);
        end
        irq_is(1'b1);
        ack();
    endtask : t_nibbles

    task automatic t_wrap;
        msk(8'h40);
        wctl(8'h84);
        wctl(8'h80);
        repeat (255) err_pulse();
        irq_is(1'b0);
        err_pulse();
        irq_is(1'b1);
        ack();
    endtask : t_wrap

    task automatic t_streams;
        wctl(8'h00);
        @(negedge hclk);
        chk("data oe off", 32'h0, {31'h0, data_out_oe});
        chk("ctrl oe off", 32'h0, {31'h0, control_out_oe});
        wctl(8'h80);
        bus(1'b1, 32'h84, 32'h3);
        @(posedge hclk);
        loss_of_signal    <= 1'b1;
        loss_mf_sync      <= 1'b1;
        data_stream_in    <= 1'b1;
        control_stream_in <= 1'b1;
        irq_is(1'b0);
        chk("data oe alarm", 32'h0, {31'h0, data_out_oe});
        chk("ctrl oe alarm", 32'h0, {31'h0, control_out_oe});
        chk("data out", 32'h1, {31'h0, data_out_stream});
        chk("ctrl out", 32'h1, {31'h0, control_out_stream});
        @(posedge hclk);
        loss_of_signal <= 1'b0;
        loss_mf_sync   <= 1'b0;
        irq_is(1'b0);
        chk("data oe on", 32'h1, {31'h0, data_out_oe});
        chk("ctrl oe on", 32'h1, {31'h0, control_out_oe});
    endtask : t_streams

    task automatic t_modes;
        @(posedge hclk);
        control_in_slot     <= 8'h5a;
        sig_register_nibble <= 4'h3;
        wctl(8'h98);
        irq_is(1'b0);
        chk("ccs", 32'h1, {31'h0, tx_common_channel_mode});
        chk("reg nibble", 32'h3, {28'h0, tx_sig_nibble});
        wctl(8'h82);
        irq_is(1'b0);
        chk("cas", 32'h0, {31'h0, tx_common_channel_mode});
        chk("upper nibble", 32'h5, {28'h0, tx_sig_nibble});
        wctl(8'h80);
        irq_is(1'b0);
        chk("lower nibble", 32'ha, {28'h0, tx_sig_nibble});
    endtask : t_modes

    // eight rises a frame
    task automatic t_slow;
        wctl(8'h81);
        rises(25600);
        chk("tx rises", 32'd8, t);
        rises(26112);
        chk("rx rises", 32'd8, r);
        wctl(8'h80);
        rises(3200);
        chk("tx rises off", 32'd0, t);
    endtask : t_slow

    task automatic finish_test;
        $display("mismatches %0d checks %0d", err_total, n_tests);
        if (err_total == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : finish_test

    ////////////////////////////////////////////////////////////////////////
    initial begin
        {hresetn, hsel, hwrite, test_error, natbit_strobe, nibble_strobe} = 6'h00;
        {loss_of_signal, loss_frame_sync, loss_crc_sync, rx_all_ones} = 4'h0;
        {loss_mf_sync, rx_ais16, data_stream_in, control_stream_in} = 4'h0;
        {haddr, hwdata} = 64'h0;
        htrans = 2'b00;
        hsize = 3'b010;
        rx_natbits = 4'h0;
        rx_nibbles = 16'h0000;
        control_in_slot = 8'h00;
        sig_register_nibble = 4'h0;
        ctl = 8'h00;
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        t_reset();
        t_error();
        t_suspend();
        t_natbits();
        t_nibbles();
        t_wrap();
        t_streams();
        t_modes();
        t_slow();
        finish_test();
    end
endmodule : tb
